// ===== cct_pkg.sv
package cct_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] CCT_IDX_STATUS = 8'h40;
  localparam logic [7:0] CCT_IDX_CNT_HI = 8'h41;
  localparam logic [7:0] CCT_IDX_CNT_LO = 8'h42;
  localparam logic [7:0] CCT_IDX_MOD_HI = 8'h43;
  localparam logic [7:0] CCT_IDX_MOD_LO = 8'h44;
  localparam logic [7:0] CCT_IDX_SC0 = 8'h45;
  localparam logic [7:0] CCT_IDX_VAL0_HI = 8'h46;
  localparam logic [7:0] CCT_IDX_VAL0_LO = 8'h47;
  localparam logic [7:0] CCT_IDX_SC1 = 8'h48;
  localparam logic [7:0] CCT_IDX_VAL1_HI = 8'h49;
  localparam logic [7:0] CCT_IDX_VAL1_LO = 8'h4A;

  // Bit positions in the timer status/control register.
  localparam int CCT_ST_FLAG = 7;
  localparam int CCT_ST_IE = 6;
  localparam int CCT_ST_STOP = 5;
  localparam int CCT_ST_CRST = 4;

  // Bit positions in a channel status/control register.
  localparam int CCT_CH_FLAG = 7;
  localparam int CCT_CH_IE = 6;
  localparam int CCT_CH_MSB = 5;
  localparam int CCT_CH_MSA = 4;
  localparam int CCT_CH_ELSB = 3;
  localparam int CCT_CH_ELSA = 2;
  localparam int CCT_CH_TOV = 1;
  localparam int CCT_CH_MAX = 0;

  // Values after reset and special codes.
  localparam logic [15:0] CCT_MOD_RST = 16'hFFFF;
  localparam logic [15:0] CCT_CNT_RST = 16'h0000;
  localparam logic [2:0] CCT_SEL_EXT = 3'h7;
  localparam logic [2:0] CCT_SEL_RST = 3'h0;

endpackage : cct_pkg

// ===== cct_timer.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module cct_timer
  import cct_pkg::*;
(
  input wire logic clk_i,               // Bus clock, 50 MHz.
  input wire logic rst_i,               // Synchronous reset, active high.
  input wire logic cyc_i,               // Wishbone cycle.
  input wire logic stb_i,               // Wishbone strobe.
  input wire logic we_i,                // Wishbone write enable.
  input wire logic [9:0] adr_i,         // Wishbone byte address.
  input wire logic [3:0] sel_i,         // Wishbone byte selects.
  input wire logic [31:0] dat_i,        // Wishbone write data.
  output logic [31:0] dat_o,            // Wishbone read data.
  output logic ack_o,                   // Wishbone acknowledge.
  input wire logic brk_i,               // Debug break in effect.
  input wire logic ext_clk_i,           // External counter clock pin.
  input wire logic [1:0] chan_pin_i,    // Channel pin levels.
  output logic [1:0] chan_pin_o,        // Channel pin drive values.
  output logic [1:0] chan_oe_o,         // Channel pin output enables.
  output logic ovf_irq_o,               // Overflow interrupt request.
  output logic [1:0] ch_irq_o           // Channel interrupt requests.
);

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [15:0] cnt;
    logic [5:0] presc;
    logic ext_prev;
    logic ovf_flag;
    logic ovf_arm;
    logic ovf_ie;
    logic stop;
    logic [2:0] clk_sel;
    logic mod_inh;
    logic [15:0] modv;
    logic cnt_lat;
    logic [7:0] cnt_buf;
    logic [1:0] ch_flag;
    logic [1:0] ch_arm;
    logic [1:0] ch_ie;
    logic buf_mode;
    logic buf_act;
    logic buf_last;
    logic [1:0] ch_msa;
    logic [1:0] ch_elsb;
    logic [1:0] ch_elsa;
    logic [1:0] ch_tov;
    logic [1:0] ch_max;
    logic [1:0] ch_max_act;
    logic [1:0] ch_inh;
    logic [1:0] ch_out;
    logic [1:0] pin_prev;
    logic [1:0][15:0] ch_val;
  } cct_state_t;

  cct_state_t st_reg;
  cct_state_t st_next;

  logic acc;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wd;
  logic run;
  logic tick;
  logic adv;
  logic ovf_evt;
  logic ovf_set;
  logic [5:0] mask;
  logic [1:0] capm;
  logic [1:0] cmpm;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [15:0] cval0;
  logic c;

  // Next-state logic: counter, bus access, then channel events.
  always_comb begin
    st_next = st_reg;
    st_next.ack = cyc_i & stb_i & ~st_reg.ack;
    acc = st_next.ack;
    wr = acc & we_i & sel_i[0];
    rd = acc & ~we_i;
    idx = adr_i[9:2];
    wd = dat_i[7:0];
    c = 1'b0;
    run = ~st_reg.stop & ~brk_i;
    st_next.ext_prev = ext_clk_i;
    mask = 6'((7'h01 << st_reg.clk_sel) - 7'h01);
    // Clock select: prescaler taps or external pin rising edge.
    if (st_reg.clk_sel == CCT_SEL_EXT) begin
      tick = ext_clk_i & ~st_reg.ext_prev;
    end else begin
      tick = (st_reg.presc & mask) == mask;
    end
    if (run) begin
      st_next.presc = st_reg.presc + 6'h01;
    end
    adv = run & tick;
    ovf_evt = adv & (st_reg.cnt == st_reg.modv);
    ovf_set = ovf_evt & ~st_reg.mod_inh;
    if (adv) begin
      st_next.cnt = ovf_evt ? CCT_CNT_RST : st_reg.cnt + 16'h0001;
    end
    // Channel modes; channel 1 is disabled in buffered mode.
    for (int i = 0; i < 2; i++) begin
      capm[i] = ~(i == 1 && st_reg.buf_mode) & ~(i == 0 && st_reg.buf_mode) & ~st_reg.ch_msa[i] &
                (st_reg.ch_elsb[i] | st_reg.ch_elsa[i]);
      cmpm[i] = ~(i == 1 && st_reg.buf_mode) & ((i == 0 && st_reg.buf_mode) | st_reg.ch_msa[i]) &
                (st_reg.ch_elsb[i] | st_reg.ch_elsa[i]);
    end
    // Register bus reads and writes; unmapped indices read zero.
    if (acc) begin
      st_next.dat = 8'h00;
      case (idx)
        CCT_IDX_STATUS: begin
          if (rd) begin
            st_next.dat = {st_reg.ovf_flag, st_reg.ovf_ie, st_reg.stop, 2'b00, st_reg.clk_sel};
            st_next.ovf_arm = st_reg.ovf_flag;
          end else if (wr) begin
            if (st_reg.ovf_arm && !wd[CCT_ST_FLAG]) begin
              st_next.ovf_flag = 1'b0;
            end
            st_next.ovf_arm = 1'b0;
            st_next.ovf_ie = wd[CCT_ST_IE];
            st_next.stop = wd[CCT_ST_STOP];
            st_next.clk_sel = wd[2:0];
            if (wd[CCT_ST_CRST]) begin
              st_next.cnt = CCT_CNT_RST;
              st_next.presc = 6'h00;
            end
          end
        end
        CCT_IDX_CNT_HI: begin
          if (rd) begin
            st_next.dat = st_reg.cnt[15:8];
            if (!st_reg.cnt_lat) begin
              st_next.cnt_lat = 1'b1;
              st_next.cnt_buf = st_reg.cnt[7:0];
            end
          end
        end
        CCT_IDX_CNT_LO: begin
          if (rd) begin
            st_next.dat = st_reg.cnt_lat ? st_reg.cnt_buf : st_reg.cnt[7:0];
            st_next.cnt_lat = 1'b0;
          end
        end
        CCT_IDX_MOD_HI: begin
          if (rd) begin
            st_next.dat = st_reg.modv[15:8];
          end else if (wr) begin
            st_next.modv[15:8] = wd;
            st_next.mod_inh = 1'b1;
          end
        end
        CCT_IDX_MOD_LO: begin
          if (rd) begin
            st_next.dat = st_reg.modv[7:0];
          end else if (wr) begin
            st_next.modv[7:0] = wd;
            st_next.mod_inh = 1'b0;
          end
        end
        CCT_IDX_SC0, CCT_IDX_SC1: begin
          c = (idx == CCT_IDX_SC1);
          if (!(c && st_reg.buf_mode)) begin
            if (rd) begin
              st_next.dat = {st_reg.ch_flag[c], st_reg.ch_ie[c], st_reg.buf_mode & ~c, st_reg.ch_msa[c],
                             st_reg.ch_elsb[c], st_reg.ch_elsa[c], st_reg.ch_tov[c], st_reg.ch_max[c]};
              st_next.ch_arm[c] = st_reg.ch_flag[c];
            end else if (wr) begin
              if (st_reg.ch_arm[c] && !wd[CCT_CH_FLAG]) begin
                st_next.ch_flag[c] = 1'b0;
              end
              st_next.ch_arm[c] = 1'b0;
              st_next.ch_ie[c] = wd[CCT_CH_IE];
              if (!c) begin
                st_next.buf_mode = wd[CCT_CH_MSB];
                if (wd[CCT_CH_MSB] && !st_reg.buf_mode) begin
                  st_next.buf_act = 1'b0;
                  st_next.buf_last = 1'b0;
                end
              end
              st_next.ch_msa[c] = wd[CCT_CH_MSA];
              st_next.ch_elsb[c] = wd[CCT_CH_ELSB];
              st_next.ch_elsa[c] = wd[CCT_CH_ELSA];
              st_next.ch_tov[c] = wd[CCT_CH_TOV];
              st_next.ch_max[c] = wd[CCT_CH_MAX];
            end
          end
        end
        CCT_IDX_VAL0_HI, CCT_IDX_VAL1_HI: begin
          c = (idx == CCT_IDX_VAL1_HI);
          if (rd) begin
            st_next.dat = st_reg.ch_val[c][15:8];
            if (capm[c]) begin
              st_next.ch_inh[c] = 1'b1;
            end
          end else if (wr) begin
            st_next.ch_val[c][15:8] = wd;
            st_next.buf_last = c;
            if (cmpm[c] || (c && st_reg.buf_mode)) begin
              st_next.ch_inh[c] = 1'b1;
            end
          end
        end
        CCT_IDX_VAL0_LO, CCT_IDX_VAL1_LO: begin
          c = (idx == CCT_IDX_VAL1_LO);
          if (rd) begin
            st_next.dat = st_reg.ch_val[c][7:0];
            st_next.ch_inh[c] = 1'b0;
          end else if (wr) begin
            st_next.ch_val[c][7:0] = wd;
            st_next.buf_last = c;
            st_next.ch_inh[c] = 1'b0;
          end
        end
        default: begin
          st_next.dat = 8'h00;
        end
      endcase
    end
    // Overflow events win over a clear in the same cycle.
    if (ovf_set) begin
      st_next.ovf_flag = 1'b1;
      st_next.ovf_arm = 1'b0;
    end
    if (ovf_evt && st_reg.buf_mode) begin
      st_next.buf_act = st_reg.buf_last;
    end
    // Channel capture, compare and pin output behaviour.
    cval0 = st_reg.buf_mode ? st_reg.ch_val[st_reg.buf_act] : st_reg.ch_val[0];
    for (int i = 0; i < 2; i++) begin
      st_next.pin_prev[i] = chan_pin_i[i];
      rise[i] = chan_pin_i[i] & ~st_reg.pin_prev[i];
      fall[i] = ~chan_pin_i[i] & st_reg.pin_prev[i];
      cap_evt[i] = capm[i] & run & ~st_reg.ch_inh[i] &
                   ((st_reg.ch_elsa[i] & rise[i]) | (st_reg.ch_elsb[i] & fall[i]));
      cmp_evt[i] = cmpm[i] & adv & ~st_reg.ch_inh[i] &
                   (st_reg.cnt == ((i == 0) ? cval0 : st_reg.ch_val[1]));
      if (cap_evt[i]) begin
        st_next.ch_val[i] = st_reg.cnt;
      end
      if (cap_evt[i] || cmp_evt[i]) begin
        st_next.ch_flag[i] = 1'b1;
        st_next.ch_arm[i] = 1'b0;
      end
      if (ovf_evt) begin
        st_next.ch_max_act[i] = st_reg.ch_max[i];
      end
      if (!st_reg.ch_elsb[i] && !st_reg.ch_elsa[i]) begin
        st_next.ch_out[i] = ~st_reg.ch_msa[i];
      end else if (cmpm[i]) begin
        if (ovf_evt && st_reg.ch_tov[i]) begin
          // Overflow action wins over a coincident compare.
          if (st_reg.ch_max_act[i] && st_reg.ch_elsb[i]) begin
            st_next.ch_out[i] = ~st_reg.ch_elsa[i];
          end else begin
            st_next.ch_out[i] = ~st_reg.ch_out[i];
          end
        end else if (cmp_evt[i] && !(st_reg.ch_max_act[i] && st_reg.ch_tov[i])) begin
          // Compare action; without overflow toggling, clear and set settle at one level, toggle flips on each match.
          case ({st_reg.ch_elsb[i], st_reg.ch_elsa[i]})
            2'b01: st_next.ch_out[i] = ~st_reg.ch_out[i];
            2'b10: st_next.ch_out[i] = 1'b0;
            default: st_next.ch_out[i] = 1'b1;
          endcase
        end
      end
    end
  end

  // State register with reset values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.stop <= 1'b1;
      st_reg.clk_sel <= CCT_SEL_RST;
      st_reg.modv <= CCT_MOD_RST;
      st_reg.cnt <= CCT_CNT_RST;
      st_reg.ch_out <= 2'b11;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus and pin outputs.
  assign dat_o = {24'h000000, st_reg.dat};
  assign ack_o = st_reg.ack;
  assign chan_pin_o = st_reg.ch_out;
  assign chan_oe_o = cmpm;
  assign ovf_irq_o = st_reg.ovf_flag & st_reg.ovf_ie;
  assign ch_irq_o = st_reg.ch_flag & st_reg.ch_ie;

  // Checks on the counter, flags and channels.
  stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.stop && !(wr && idx == CCT_IDX_STATUS) |=> $stable(st_reg.cnt))
    else $error("Counter moved while stopped.");
  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_evt && !st_reg.mod_inh |=> st_reg.ovf_flag && st_reg.cnt == 16'h0000)
    else $error("Overflow did not set flag and wrap.");
  ovf_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_set && st_reg.ovf_ie && !(wr && idx == CCT_IDX_STATUS) |=> ovf_irq_o)
    else $error("Overflow request missing.");
  cnt_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == CCT_IDX_STATUS && wd[CCT_ST_CRST] |=> st_reg.cnt == 16'h0000 && st_reg.presc == 6'h00)
    else $error("Counter reset bit did not clear counter.");
  cnt_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    adv && !ovf_evt && !(wr && idx == CCT_IDX_STATUS) |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("Counter did not step by one.");
  mod_inh_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.mod_inh && !st_reg.ovf_flag |=> !st_reg.ovf_flag)
    else $error("Overflow flag set during modulo update.");
  cap_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.stop || brk_i || st_reg.ch_inh[0]) && capm[0] &&
    !(wr && (idx == CCT_IDX_VAL0_HI || idx == CCT_IDX_VAL0_LO)) |=> $stable(st_reg.ch_val[0]))
    else $error("Capture while stopped or blocked.");
  ch_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_evt[1] || cap_evt[1] |=> st_reg.ch_flag[1] ##1 st_reg.ch_flag[1] || $past(wr))
    else $error("Channel flag not set by event.");
  cnt_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.cnt_lat && !(rd && idx == CCT_IDX_CNT_LO) |=> $stable(st_reg.cnt_buf))
    else $error("Latched low count byte changed.");

endmodule : cct_timer

// ===== cct_pin_model.sv
`timescale 1ns/1ps
// Far side of the timer: external clock pin and the two channel pins.
module cct_pin_model (
  input wire logic clk_i,               // Bus clock, paces the pins.
  input wire logic [1:0] chan_pin_o,    // Timer drive values.
  input wire logic [1:0] chan_oe_o,     // Timer output enables.
  output logic ext_clk_i,               // External clock pin.
  output logic [1:0] chan_pin_i         // Resolved channel pin levels.
);
  logic [1:0] port_lvl;
  // A pin that the timer does not drive stays under port control.
  assign chan_pin_i = (chan_oe_o & chan_pin_o) | (~chan_oe_o & port_lvl);
  // Both pins idle low; the clock stands still between bursts.
  initial begin
    ext_clk_i = 1'b0;
    port_lvl = 2'h0;
  end
  // Sends n clock pulses, high for four bus clocks and low for five.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulse
  // Sets the port level of one channel pin just after an edge.
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk_i);
    port_lvl[ch] <= v;
  endtask : set_pin
endmodule : cct_pin_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import cct_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, brk_i, ext_clk_i, ovf_irq_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [1:0] chan_pin_i, chan_pin_o, chan_oe_o, ch_irq_o;
  logic [7:0] rv;
  logic [15:0] cv, c0;
  int fail_count, check_count;

  // Timer and the model of its pins.
  cct_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .brk_i(brk_i),
    .ext_clk_i(ext_clk_i), .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o),
    .chan_oe_o(chan_oe_o), .ovf_irq_o(ovf_irq_o), .ch_irq_o(ch_irq_o));
  cct_pin_model pm_u (.clk_i(clk_i), .chan_pin_o(chan_pin_o), .chan_oe_o(chan_oe_o),
    .ext_clk_i(ext_clk_i), .chan_pin_i(chan_pin_i));

  // 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; holds the request until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk(16'h0000, 16'h0001);
    rv = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  // Reads a register and compares it.
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({8'h00, rv}, {8'h00, exp});
  endtask : rdc

  // Reads the counter, high byte first so the low byte is latched.
  task automatic rdcnt;
    bus(1'b0, CCT_IDX_CNT_HI, 8'h00);
    cv[15:8] = rv;
    bus(1'b0, CCT_IDX_CNT_LO, 8'h00);
    cv[7:0] = rv;
  endtask : rdcnt

  // Reset values and an unmapped place.
  task automatic t_reset;
    rdc(CCT_IDX_STATUS, 8'h20);
    rdc(CCT_IDX_MOD_HI, 8'hFF);
    rdc(CCT_IDX_MOD_LO, 8'hFF);
    rdcnt();
    chk(cv, 16'h0000);
    rdc(8'h10, 8'h00);
  endtask : t_reset

  // Each divider runs for 131 clocks, so it counts 131 shifted right by its code.
  task automatic t_prescale;
    for (int k = 0; k < 7; k++) begin
      wr(CCT_IDX_STATUS, 8'h30);
      wr(CCT_IDX_STATUS, 8'(k));
      repeat (128) @(posedge clk_i);
      wr(CCT_IDX_STATUS, 8'(8'h20 | k));
      rdcnt();
      chk(cv, 16'h0083 >> k);
    end
    rdcnt();
    chk(cv, 16'h0083 >> 6);
    wr(CCT_IDX_STATUS, 8'h30);
    rdc(CCT_IDX_STATUS, 8'h20);
    rdcnt();
    chk(cv, 16'h0000);
    wr(CCT_IDX_STATUS, 8'h07);
    pm_u.pulse(5);
    wr(CCT_IDX_STATUS, 8'h27);
    rdcnt();
    chk(cv, 16'h0005);
  endtask : t_prescale

  // Suppressed overflow, flag, request and the two-step clear.
  task automatic t_overflow;
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_MOD_LO, 8'h03);
    wr(CCT_IDX_MOD_HI, 8'h00);
    wr(CCT_IDX_STATUS, 8'h40);
    repeat (20) @(posedge clk_i);
    rdc(CCT_IDX_STATUS, 8'h40);
    wr(CCT_IDX_MOD_LO, 8'h03);
    repeat (10) @(posedge clk_i);
    rdc(CCT_IDX_STATUS, 8'hC0);
    chk({15'h0000, ovf_irq_o}, 16'h0001);
    repeat (8) @(posedge clk_i);
    wr(CCT_IDX_STATUS, 8'h60);
    rdc(CCT_IDX_STATUS, 8'hE0);
    wr(CCT_IDX_STATUS, 8'hE0);
    rdc(CCT_IDX_STATUS, 8'hE0);
    wr(CCT_IDX_STATUS, 8'h60);
    rdc(CCT_IDX_STATUS, 8'h60);
    chk({15'h0000, ovf_irq_o}, 16'h0000);
  endtask : t_overflow

  // Rising-edge capture on channel 0, blocked while stopped.
  task automatic t_capture;
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_VAL0_HI, 8'hAB);
    wr(CCT_IDX_VAL0_LO, 8'hCD);
    wr(CCT_IDX_SC0, 8'h04);
    pm_u.set_pin(0, 1'b1);
    repeat (4) @(posedge clk_i);
    rdc(CCT_IDX_SC0, 8'h04);
    wr(CCT_IDX_STATUS, 8'h06);
    pm_u.set_pin(0, 1'b0);
    repeat (4) @(posedge clk_i);
    rdc(CCT_IDX_SC0, 8'h04);
    pm_u.set_pin(0, 1'b1);
    repeat (4) @(posedge clk_i);
    rdc(CCT_IDX_SC0, 8'h84);
    rdc(CCT_IDX_VAL0_HI, 8'h00);
    rdc(CCT_IDX_VAL0_LO, 8'h00);
    wr(CCT_IDX_SC0, 8'h04);
    rdc(CCT_IDX_SC0, 8'h04);
  endtask : t_capture

  // Channel 1 compare, held off by a lone high write; then buffered mode.
  task automatic t_compare;
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_MOD_LO, 8'h07);
    wr(CCT_IDX_SC1, 8'h54);
    chk({14'h0000, chan_oe_o}, 16'h0002);
    wr(CCT_IDX_VAL1_HI, 8'h00);
    wr(CCT_IDX_STATUS, 8'h00);
    repeat (20) @(posedge clk_i);
    rdc(CCT_IDX_SC1, 8'h54);
    wr(CCT_IDX_VAL1_LO, 8'h03);
    repeat (20) @(posedge clk_i);
    rdc(CCT_IDX_SC1, 8'hD4);
    chk({14'h0000, ch_irq_o}, 16'h0002);
    wr(CCT_IDX_SC0, 8'h28);
    rdc(CCT_IDX_SC1, 8'h00);
    chk({14'h0000, chan_oe_o}, 16'h0001);
  endtask : t_compare

  // Counts the cycles in which channel 0 drives high over n clocks.
  task automatic count_high(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (chan_pin_o[0] === 1'b1) hi++;
    end
  endtask : count_high

  // Preset levels, then 0%, toggled and 100% duty on channel 0 with period 8.
  task automatic t_pwm;
    int hi;
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_SC0, 8'h00);
    @(posedge clk_i);
    chk({15'h0000, chan_pin_o[0]}, 16'h0001);
    wr(CCT_IDX_SC0, 8'h10);
    @(posedge clk_i);
    chk({14'h0000, chan_oe_o[0], chan_pin_o[0]}, 16'h0000);
    wr(CCT_IDX_SC0, 8'h18);
    wr(CCT_IDX_VAL0_HI, 8'h00);
    wr(CCT_IDX_VAL0_LO, 8'h02);
    wr(CCT_IDX_STATUS, 8'h00);
    count_high(32, hi);
    chk(16'(hi), 16'h0000);
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_SC0, 8'h1A);
    wr(CCT_IDX_STATUS, 8'h00);
    repeat (8) @(posedge clk_i);
    count_high(32, hi);
    chk(16'(hi), 16'h000C);
    wr(CCT_IDX_SC0, 8'h1B);
    repeat (16) @(posedge clk_i);
    count_high(16, hi);
    chk(16'(hi), 16'h0010);
  endtask : t_pwm

  // Debug break freezes a running counter.
  task automatic t_break;
    wr(CCT_IDX_STATUS, 8'h30);
    wr(CCT_IDX_STATUS, 8'h00);
    brk_i <= 1'b1;
    rdcnt();
    c0 = cv;
    repeat (11) @(posedge clk_i);
    rdcnt();
    chk(cv, c0);
    brk_i <= 1'b0;
  endtask : t_break

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 10'h000;
    sel_i = 4'hF;
    dat_i = 32'h00000000;
    brk_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prescale();
    t_overflow();
    t_capture();
    t_compare();
    t_pwm();
    t_break();
    conclude();
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
endmodule : testbench
